// *** rtl/twi_slave_pkg.sv ***
// Purpose: Shared constants and types for the two-wire register slave.
// Assumes: 8-bit register pointer and 16-bit register words.
// Notes:   The slave addresses, bit counts and pointer and word reset values live here.
package twi_slave_pkg;

  // Slave address bytes, write form and read form.
  localparam logic [7:0] SLV_WR_ADDR = 8'hBA;
  localparam logic [7:0] SLV_RD_ADDR = 8'hBB;

  // Bits per byte on the wire, and the bit counter reset value.
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] BIT_STEP    = 4'h1;

  // Register pointer and data reset values.
  localparam logic [7:0]  PTR_RST  = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // Protocol phases of the link engine.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEV  = 3'b001,
    ST_REG  = 3'b010,
    ST_WR   = 3'b011,
    ST_ACK  = 3'b100,
    ST_RD   = 3'b101,
    ST_RACK = 3'b110
  } link_state_t;

endpackage

// *** rtl/sync2.sv ***
// Purpose: Two-flop synchroniser for levels entering a clock domain.
// Assumes: Each bit is an independent level; no reset is needed.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/100ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);

  logic [W-1:0] meta;

  // Two back-to-back stages settle a possibly metastable sample.
  always_ff @(posedge clk_in) begin
    meta  <= d_in;
    q_out <= meta;
  end

endmodule

// *** rtl/cdc_word.sv ***
// Purpose: Toggle handshake that carries one word from one clock to another.
// Assumes: The sender waits for busy_out low before sending again.
// Notes:   The word is held stable in the source until the far side has it.
`timescale 1ns/100ps
module cdc_word #(
  parameter int W = 8
) (
  input  wire logic         src_clk_in,
  input  wire logic         src_rst_in,
  input  wire logic         send_in,
  input  wire logic [W-1:0] data_in,
  output logic              busy_out,
  input  wire logic         dst_clk_in,
  input  wire logic         dst_rst_in,
  output logic              pulse_out,
  output logic      [W-1:0] data_out
);

  logic         req_tgl;
  logic [W-1:0] hold;
  logic         ack_s;
  logic         req_s;
  logic         req_d;
  wire          req_new = req_s ^ req_d;

  // Source side latches the word and flips the request toggle.
  always_ff @(posedge src_clk_in) begin
    if (src_rst_in) begin
      req_tgl <= 1'b0;
      hold    <= '0;
    end else if (send_in && !busy_out) begin
      req_tgl <= ~req_tgl;
      hold    <= data_in;
    end
  end

  // Busy until the destination's copy of the toggle returns.
  assign busy_out = req_tgl ^ ack_s;

  sync2 #(.W(1)) u_req_sync (.clk_in(dst_clk_in), .d_in(req_tgl), .q_out(req_s));
  sync2 #(.W(1)) u_ack_sync (.clk_in(src_clk_in), .d_in(req_d), .q_out(ack_s));

  // Destination side turns each toggle into one pulse with the word.
  always_ff @(posedge dst_clk_in) begin
    if (dst_rst_in) begin
      req_d     <= 1'b0;
      pulse_out <= 1'b0;
      data_out  <= '0;
    end else begin
      req_d     <= req_s;
      pulse_out <= req_new;
      if (req_new) begin
        data_out <= hold;
      end
    end
  end

endmodule

// *** rtl/two_wire_register_slave.sv ***
// Purpose: Two-wire serial slave giving a bus master access to 16-bit registers.
// Assumes: Register data returns on reg_rdata_in the cycle after reg_rd_out.
// Assumes: link_clk_in runs free and is much faster than the serial clock.
// Notes:   The protocol engine runs on link_clk_in; register strobes on core_clk_in.
// Notes on behaviour
// - Slave only; the serial clock is never driven, only sampled.
// - Data line is open drain; pull low only in our own phases.
// - Both lines high means idle; nothing is driven then.
// - Start is data falling while clock high; detect it anywhere.
// - Acknowledge a matching slave address in the next clock slot.
// - In a write the register address follows and is acknowledged.
// - Every written data byte gets an acknowledge after eight bits.
// - Registers are 16 bits, moved as two bytes, high byte first.
// - Pointer steps by one after each full 16-bit write.
// - In a read bytes are shifted out; master acknowledges each one.
// - Pointer steps by one after every 16 bits read.
// - Master no-acknowledge ends a read; data line is released.
// - Stop is data rising while clock high; detect it anywhere.
// - Slave answers address byte 0xBA for write, 0xBB for read.
// - Data changes only while the clock is low.
// - Receiver pulls data low through the acknowledge clock pulse.
`timescale 1ns/100ps
module two_wire_register_slave #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic          core_clk_in,
  input  wire logic          srst_in,
  input  wire logic          link_clk_in,
  input  wire logic          serial_clock_in,
  input  wire logic          serial_data_line_in,
  output logic               serial_data_line_out,
  output logic               serial_data_line_oe_out,
  output logic               reg_wr_out,
  output logic               reg_rd_out,
  output logic      [AW-1:0] reg_addr_out,
  output logic      [DW-1:0] reg_wdata_out,
  input  wire logic [DW-1:0] reg_rdata_in
);

  localparam int CW = 1 + AW + DW;

  // Link domain state, then the core domain side of the command path.
  logic                     link_rst;
  logic [1:0]               pins_s;
  logic                     scl_s;
  logic                     sda_s;
  logic                     scl_d;
  logic                     sda_d;
  twi_slave_pkg::link_state_t state;
  twi_slave_pkg::link_state_t next_state;
  twi_slave_pkg::link_state_t after_ack;
  logic [3:0]               bit_cnt;
  logic [7:0]               shreg;
  logic [7:0]               txreg;
  logic [AW-1:0]            ptr;
  logic [7:0]               wbuf;
  logic                     hi_lo;
  logic                     ack_seen;
  logic                     next_oe;
  logic [DW-1:0]            rbuf;
  logic                     cmd_busy;
  logic                     rsp_pulse;
  logic [DW-1:0]            rsp_word;
  logic                     cmd_pulse;
  logic [CW-1:0]            cmd_word;
  logic                     rsp_pend;

  // The reset is a level; it reaches the link domain through two flops.
  sync2 #(.W(1)) u_rst_sync (
    .clk_in (link_clk_in),
    .d_in   (srst_in),
    .q_out  (link_rst)
  );
  // Both bus lines are brought into the link domain before use.
  sync2 #(.W(2)) u_pin_sync (
    .clk_in (link_clk_in),
    .d_in   ({serial_clock_in, serial_data_line_in}),
    .q_out  (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  // Delayed copies give the edges of the synchronised lines.
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Line events: start, stop and clock edges.
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;
  wire scl_rise   = scl_s & ~scl_d;
  wire scl_fall   = ~scl_s & scl_d;
  wire frame_evt  = start_cond | stop_cond;
  // Byte reception and address decode.
  wire rx_st     = (state == twi_slave_pkg::ST_DEV) | (state == twi_slave_pkg::ST_REG)
                 | (state == twi_slave_pkg::ST_WR);
  wire byte_full = (bit_cnt == twi_slave_pkg::BYTE_BITS);
  wire rx_bit    = rx_st & scl_rise & ~byte_full;
  wire rx_done   = rx_st & scl_fall & byte_full;
  wire addr_hit  = (shreg == twi_slave_pkg::SLV_WR_ADDR)
                 | (shreg == twi_slave_pkg::SLV_RD_ADDR);
  wire dev_done  = rx_done & (state == twi_slave_pkg::ST_DEV);
  wire dev_ok    = dev_done & addr_hit;
  wire dev_rd    = dev_ok & shreg[0];
  wire reg_done  = rx_done & (state == twi_slave_pkg::ST_REG);
  wire wr_done   = rx_done & (state == twi_slave_pkg::ST_WR);
  wire wr_send   = wr_done & hi_lo;
  // Transmit and acknowledge slot events.
  wire ack_end   = (state == twi_slave_pkg::ST_ACK) & scl_fall;
  wire rd_st     = (state == twi_slave_pkg::ST_RD);
  wire last_bit  = (bit_cnt == twi_slave_pkg::LAST_BIT);
  wire tx_shift  = rd_st & scl_fall & ~last_bit;
  wire tx_done   = rd_st & scl_fall & last_bit;
  wire rack_end  = (state == twi_slave_pkg::ST_RACK) & scl_fall;
  wire rd_next   = tx_done & hi_lo;
  wire [7:0] tx_byte = hi_lo ? rbuf[7:0] : rbuf[DW-1:8];
  wire       tx_load = ack_end | rack_end;
  // Register pointer step and the command sent to the core side.
  wire [AW-1:0] ptr_inc  = ptr + {{(AW-1){1'b0}}, 1'b1};
  wire          rd_send  = dev_rd | rd_next;
  wire          cmd_send = wr_send | rd_send;
  wire [AW-1:0] cmd_addr = rd_next ? ptr_inc : ptr;
  wire [CW-1:0] cmd_data = {wr_send, cmd_addr, wbuf, shreg};

  // Phase sequencing; start and stop win over everything else.
  always_comb begin
    next_state = state;
    if (start_cond) begin
      next_state = twi_slave_pkg::ST_DEV;
    end else if (stop_cond) begin
      next_state = twi_slave_pkg::ST_IDLE;
    end else begin
      case (state)
        twi_slave_pkg::ST_DEV, twi_slave_pkg::ST_REG, twi_slave_pkg::ST_WR: begin
          if (dev_done && !addr_hit) begin
            next_state = twi_slave_pkg::ST_IDLE;
          end else if (rx_done) begin
            next_state = twi_slave_pkg::ST_ACK;
          end
        end
        twi_slave_pkg::ST_ACK: begin
          if (scl_fall) begin
            next_state = after_ack;
          end
        end
        twi_slave_pkg::ST_RD: begin
          if (tx_done) begin
            next_state = twi_slave_pkg::ST_RACK;
          end
        end
        twi_slave_pkg::ST_RACK: begin
          if (rack_end) begin
            next_state = ack_seen ? twi_slave_pkg::ST_RD : twi_slave_pkg::ST_IDLE;
          end
        end
        default: next_state = state;
      endcase
    end
  end

  // Data line drive; only ever pulls low, and only in our own slots.
  always_comb begin
    next_oe = serial_data_line_oe_out;
    if (frame_evt) begin
      next_oe = 1'b0;
    end else if (rx_done) begin
      next_oe = ~dev_done | addr_hit;
    end else if (ack_end) begin
      next_oe = (after_ack == twi_slave_pkg::ST_RD) & ~tx_byte[7];
    end else if (tx_shift) begin
      next_oe = ~txreg[6];
    end else if (tx_done) begin
      next_oe = 1'b0;
    end else if (rack_end) begin
      next_oe = ack_seen & ~tx_byte[7];
    end
  end

  // State, output enable and the phase after the acknowledge slot.
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      state                   <= twi_slave_pkg::ST_IDLE;
      after_ack               <= twi_slave_pkg::ST_IDLE;
      serial_data_line_oe_out <= 1'b0;
    end else begin
      state                   <= next_state;
      serial_data_line_oe_out <= next_oe;
      if (rx_done) begin
        after_ack <= dev_done ? (shreg[0] ? twi_slave_pkg::ST_RD : twi_slave_pkg::ST_REG)
                              : twi_slave_pkg::ST_WR;
      end
    end
  end

  // The line is open drain, so the driven level is always low.
  assign serial_data_line_out = 1'b0;
  // Bit counter for receive and transmit bytes.
  always_ff @(posedge link_clk_in) begin
    if (link_rst || start_cond || ack_end || rack_end) begin
      bit_cnt <= twi_slave_pkg::BIT_CNT_RST;
    end else if (rx_bit || tx_shift) begin
      bit_cnt <= bit_cnt + twi_slave_pkg::BIT_STEP;
    end
  end
  // Shift registers: sample on clock rise, shift out on clock fall.
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      shreg <= 8'h00;
      txreg <= 8'h00;
    end else begin
      if (rx_bit) begin
        shreg <= {shreg[6:0], sda_s};
      end
      if (tx_load) begin
        txreg <= tx_byte;
      end else if (tx_shift) begin
        txreg <= {txreg[6:0], 1'b0};
      end
    end
  end
  // Pointer, byte half tracking and the held first data byte.
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      ptr   <= twi_slave_pkg::PTR_RST;
      wbuf  <= 8'h00;
      hi_lo <= 1'b0;
    end else begin
      if (reg_done) begin
        ptr <= shreg;
      end else if (wr_send || rd_next) begin
        ptr <= ptr_inc;
      end
      if (start_cond || reg_done || dev_ok) begin
        hi_lo <= 1'b0;
      end else if (wr_done || tx_done) begin
        hi_lo <= ~hi_lo;
      end
      if (wr_done && !hi_lo) begin
        wbuf <= shreg;
      end
    end
  end
  // Master acknowledge is sampled while the clock is high.
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      ack_seen <= 1'b0;
    end else if ((state == twi_slave_pkg::ST_RACK) && scl_rise) begin
      ack_seen <= ~sda_s;
    end
  end
  // Read data returned from the core side.
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      rbuf <= twi_slave_pkg::WORD_RST;
    end else if (rsp_pulse) begin
      rbuf <= rsp_word;
    end
  end

  // Commands cross to the core clock through a toggle handshake.
  cdc_word #(.W(CW)) u_cmd_cdc (
    .src_clk_in (link_clk_in),
    .src_rst_in (link_rst),
    .send_in    (cmd_send),
    .data_in    (cmd_data),
    .busy_out   (cmd_busy),
    .dst_clk_in (core_clk_in),
    .dst_rst_in (srst_in),
    .pulse_out  (cmd_pulse),
    .data_out   (cmd_word)
  );

  // Register strobes towards the rest of the device.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      reg_wr_out    <= 1'b0;
      reg_rd_out    <= 1'b0;
      reg_addr_out  <= twi_slave_pkg::PTR_RST;
      reg_wdata_out <= twi_slave_pkg::WORD_RST;
      rsp_pend      <= 1'b0;
    end else begin
      reg_wr_out <= cmd_pulse & cmd_word[CW-1];
      reg_rd_out <= cmd_pulse & ~cmd_word[CW-1];
      rsp_pend   <= reg_rd_out;
      if (cmd_pulse) begin
        reg_addr_out  <= cmd_word[CW-2:DW];
        reg_wdata_out <= cmd_word[DW-1:0];
      end
    end
  end

  // Read data goes back to the link domain the cycle after the strobe.
  cdc_word #(.W(DW)) u_rsp_cdc (
    .src_clk_in (core_clk_in),
    .src_rst_in (srst_in),
    .send_in    (rsp_pend),
    .data_in    (reg_rdata_in),
    .busy_out   (),
    .dst_clk_in (link_clk_in),
    .dst_rst_in (link_rst),
    .pulse_out  (rsp_pulse),
    .data_out   (rsp_word)
  );

  // Checks on the link engine and on the core-side register strobes.
  sequence s_dev_hit;
    dev_done && addr_hit;
  endsequence
  sequence s_ack_slot;
    (state == twi_slave_pkg::ST_ACK) && serial_data_line_oe_out;
  endsequence

  AST_IDLE_RELEASED: assert property (@(posedge link_clk_in) disable iff (link_rst)
    (state == twi_slave_pkg::ST_IDLE) |-> !serial_data_line_oe_out)
    else $error("Data line driven while idle.");
  AST_START_SEEN: assert property (@(posedge link_clk_in) disable iff (link_rst)
    start_cond |=> (state == twi_slave_pkg::ST_DEV) && (bit_cnt == 4'h0))
    else $error("Start not followed by address phase.");
  AST_STOP_SEEN: assert property (@(posedge link_clk_in) disable iff (link_rst)
    stop_cond |=> (state == twi_slave_pkg::ST_IDLE) && !serial_data_line_oe_out)
    else $error("Stop did not return to idle.");
  AST_ADDR_ACK: assert property (@(posedge link_clk_in) disable iff (link_rst)
    s_dev_hit |=> s_ack_slot)
    else $error("Matching slave address not acknowledged.");
  AST_ADDR_MISS: assert property (@(posedge link_clk_in) disable iff (link_rst)
    (dev_done && shreg[7:1] != 7'h5D) |=> (state == twi_slave_pkg::ST_IDLE))
    else $error("Foreign slave address was answered.");
  AST_ACK_HOLD: assert property (@(posedge link_clk_in) disable iff (link_rst)
    ((state == twi_slave_pkg::ST_ACK) && !scl_fall && !frame_evt) |=> serial_data_line_oe_out)
    else $error("Acknowledge released early.");
  AST_DRIVE_ON_LOW: assert property (@(posedge link_clk_in) disable iff (link_rst)
    $changed(serial_data_line_oe_out) |-> $past(scl_fall || frame_evt))
    else $error("Data drive changed outside a clock low edge.");
  AST_NACK_END: assert property (@(posedge link_clk_in) disable iff (link_rst)
    (rack_end && !ack_seen && !frame_evt) |=> (state == twi_slave_pkg::ST_IDLE)
      ##0 !serial_data_line_oe_out)
    else $error("Read not ended on no-acknowledge.");
  AST_WRITE_STEP: assert property (@(posedge link_clk_in) disable iff (link_rst)
    wr_send |=> (ptr == $past(ptr_inc)) && !hi_lo)
    else $error("Pointer did not step after a full write.");
  AST_CMD_FREE: assert property (@(posedge link_clk_in) disable iff (link_rst)
    cmd_send |-> !cmd_busy)
    else $error("Register command issued while the handshake was busy.");
  AST_WRITE_PAIR: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cmd_pulse && cmd_word[CW-1]) |=> reg_wr_out && (reg_wdata_out == $past(cmd_word[DW-1:0])))
    else $error("Register write lost or altered.");
  AST_READ_FETCH: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (cmd_pulse && !cmd_word[CW-1]) |=> reg_rd_out ##1 rsp_pend)
    else $error("Read fetch not issued.");

endmodule

// *** testbench/twi_master_model.sv ***
// Purpose: Behavioural bus master that drives the serial clock and pulls the data wire.
// Assumes: The data wire has a pull-up; sda_in is the resolved wire level.
// Notes:   The serial clock stands still outside frames; tasks are called by the bench.
`timescale 1ns/100ps
module twi_master_model #(
  parameter int HALF = 1500
) (
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  // Both lines released at time zero, so the bus starts idle.
  initial begin
    scl_out    = 1'b1;
    sda_oe_out = 1'b0;
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond();
    sda_oe_out = 1'b0;
    #(HALF / 2);
    scl_out = 1'b1;
    #(HALF / 2);
    sda_oe_out = 1'b1;
    #(HALF / 2);
    scl_out = 1'b0;
    #(HALF / 2);
  endtask

  // Stop: data rises while the clock is high, then both lines stay high.
  task automatic stop_cond();
    sda_oe_out = 1'b1;
    #(HALF / 2);
    scl_out = 1'b1;
    #(HALF / 2);
    sda_oe_out = 1'b0;
    #(HALF);
  endtask

  // One clock pulse; data only moves in the middle of the low half.
  task automatic bit_cycle(input logic drv_low, output logic seen);
    sda_oe_out = drv_low;
    #(HALF / 2);
    scl_out = 1'b1;
    #(HALF / 2);
    seen = sda_in;
    #(HALF / 2);
    scl_out = 1'b0;
    #(HALF / 2);
  endtask

  // Sends a byte MSB first and returns the level seen in the acknowledge slot.
  task automatic send_byte(input logic [7:0] val, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(~val[i], s);
    end
    bit_cycle(1'b0, ack);
  endtask

  // Receives a byte, then acknowledges it or leaves the slot undriven.
  task automatic recv_byte(output logic [7:0] val, input logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, val[i]);
    end
    bit_cycle(~nack, s);
  endtask
endmodule

// *** testbench/two_wire_register_slave_tb.sv ***
// Purpose: Self-checking bench for the two-wire register slave.
// Assumes: Register file is modelled here; read data returns one core cycle late.
// Notes:   Random words and addresses with a wrap-around pointer corner case.
`timescale 1ns/100ps
`define CHK(got, want) begin checks++; if ((got) !== (want)) begin err_count++; \
  $display("Error t=%0t got %0h want %0h", $time, got, want); end end
module two_wire_register_slave_tb;
  logic        core_clk_in;
  logic        link_clk_in;
  logic        srst_in;
  logic [15:0] reg_rdata_in;
  logic        scl;
  logic        m_oe;
  logic        dut_oe;
  logic        dut_drv;
  logic        reg_wr_out;
  logic        reg_rd_out;
  logic [7:0]  reg_addr_out;
  logic [15:0] reg_wdata_out;
  logic        run;
  logic [15:0] mem [256];
  logic [15:0] exp_mem [256];
  int          err_count;
  int          checks;
  int          wr_cnt;
  // Open-drain wire: low if either party pulls, else the pull-up wins.
  wire logic serial_data_line = ~(m_oe | dut_oe);

  // Core clock at 25 MHz and an unrelated 30 ns link clock.
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #7;
    forever #15 link_clk_in = ~link_clk_in;
  end

  two_wire_register_slave u_dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .link_clk_in(link_clk_in),
    .serial_clock_in(scl), .serial_data_line_in(serial_data_line),
    .serial_data_line_out(dut_drv), .serial_data_line_oe_out(dut_oe),
    .reg_wr_out(reg_wr_out), .reg_rd_out(reg_rd_out), .reg_addr_out(reg_addr_out),
    .reg_wdata_out(reg_wdata_out), .reg_rdata_in(reg_rdata_in)
  );

  twi_master_model u_mst (
    .sda_in(serial_data_line), .scl_out(scl), .sda_oe_out(m_oe)
  );

  // Register file: stores strobed writes and answers reads one cycle later.
  always @(negedge core_clk_in) begin
    if (reg_wr_out === 1'b1) begin
      mem[reg_addr_out] = reg_wdata_out;
      wr_cnt++;
    end
    if (reg_rd_out === 1'b1) begin
      reg_rdata_in = mem[reg_addr_out];
    end
  end

  // The slave may only move the data wire while the serial clock is low.
  always @(dut_oe) if (run) `CHK(scl, 1'b0)

  // Expected byte of a streamed read: high byte of each register first.
  function automatic logic [7:0] rd_byte(input logic [7:0] base, input int k);
    logic [15:0] word;
    word = exp_mem[8'(base + 8'(k / 2))];
    return (k % 2) ? word[7:0] : word[15:8];
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cuts a hang short well after the expected run of about 1.3 ms.
  initial begin
    #2_500_000;
    err_count++;
    $display("Error t=%0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    logic [7:0]  a;
    logic [7:0]  idx;
    logic [7:0]  rx;
    logic [7:0]  bad;
    logic [15:0] w;
    logic        ack;
    int          base;
    srst_in = 1'b1;
    reg_rdata_in = 16'h0000;
    run = 1'b0;
    err_count = 0;
    checks = 0;
    wr_cnt = 0;
    void'($urandom(32'hb538e364));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'($urandom);
      exp_mem[i] = mem[i];
    end
    repeat (10) @(negedge core_clk_in);
    srst_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    run = 1'b1;
    `CHK(dut_oe, 1'b0);
    `CHK(dut_drv, 1'b0);
    // Burst write of two registers, then a streamed read-back.
    for (int n = 0; n < 3; n++) begin
      a = (n == 0) ? 8'hFF : 8'($urandom);
      base = wr_cnt;
      u_mst.start_cond();
      u_mst.send_byte(8'hBA, ack);
      `CHK(ack, 1'b0);
      u_mst.send_byte(a, ack);
      `CHK(ack, 1'b0);
      for (int k = 0; k < 2; k++) begin
        w = 16'($urandom);
        idx = a + 8'(k);
        exp_mem[idx] = w;
        u_mst.send_byte(w[15:8], ack);
        `CHK(ack, 1'b0);
        u_mst.send_byte(w[7:0], ack);
        `CHK(ack, 1'b0);
      end
      u_mst.stop_cond();
      repeat (20) @(negedge core_clk_in);
      `CHK(wr_cnt, base + 2);
      `CHK(mem[a], exp_mem[a]);
      idx = a + 8'h01;
      `CHK(mem[idx], exp_mem[idx]);
      u_mst.start_cond();
      u_mst.send_byte(8'hBA, ack);
      `CHK(ack, 1'b0);
      u_mst.send_byte(a, ack);
      `CHK(ack, 1'b0);
      u_mst.start_cond();
      u_mst.send_byte(8'hBB, ack);
      `CHK(ack, 1'b0);
      for (int k = 0; k < 4; k++) begin
        u_mst.recv_byte(rx, k == 3);
        `CHK(rx, rd_byte(a, k));
      end
      `CHK(dut_oe, 1'b0);
      u_mst.stop_cond();
      `CHK(dut_oe, 1'b0);
      $display("test burst %0d done", n);
    end
    // A read with no register address streams on from the held pointer.
    u_mst.start_cond();
    u_mst.send_byte(8'hBB, ack);
    `CHK(ack, 1'b0);
    for (int k = 4; k < 6; k++) begin
      u_mst.recv_byte(rx, k == 5);
      `CHK(rx, rd_byte(a, k));
    end
    u_mst.stop_cond();
    `CHK(dut_oe, 1'b0);
    $display("test direct read done");
    // A lone data byte cut off by a repeated start to a foreign address.
    a = 8'($urandom);
    base = wr_cnt;
    bad = 8'($urandom);
    if (bad[7:1] == 7'h5D) begin
      bad = bad ^ 8'h02;
    end
    u_mst.start_cond();
    u_mst.send_byte(8'hBA, ack);
    u_mst.send_byte(a, ack);
    u_mst.send_byte(8'($urandom), ack);
    u_mst.start_cond();
    u_mst.send_byte(bad, ack);
    `CHK(ack, 1'b1);
    u_mst.stop_cond();
    repeat (20) @(negedge core_clk_in);
    `CHK(wr_cnt, base);
    `CHK(mem[a], exp_mem[a]);
    `CHK(dut_oe, 1'b0);
    $display("test odd write done");
    wrap_up();
  end
endmodule
